// [bst_pkg.sv]
// Shared constants, states and carriers of the boundary scan test port
package bst_pkg;
  localparam int DR_W = 8;                 // Width of the scan data register
  localparam int IR_W = 2;                 // Width of the instruction register
  localparam int FIFO_DEPTH = 8;           // Words buffered on the system side
  localparam int TLR_TMS_COUNT = 5;        // TMS-high edges that force reset
  localparam logic [1:0] IR_SCAN = 2'h0;   // Shift the scan data register
  localparam logic [1:0] IR_SAMPLE = 2'h1; // Capture value, also IR capture pattern
  localparam logic [1:0] IR_BYPASS = 2'h3; // One-bit bypass path
  localparam logic [1:0] IR_RESET = IR_BYPASS; // Instruction after reset
  localparam logic [7:0] DR_RESET = 8'h00; // Scan register after reset
  localparam logic [1:0] SYNC_SETTLE = 2'h3; // System clock edges before the request sync is trusted

  // Sixteen controller states
  typedef enum logic [3:0] {
    ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR = 4'hB,
    ST_EX1_IR = 4'hC, ST_PA_IR = 4'hD, ST_EX2_IR = 4'hE, ST_UPD_IR = 4'hF
  } bst_state_e;

  // Word handed from the scan path to the system side
  typedef struct packed {
    logic [7:0] data;
  } bst_word_s;
endpackage : bst_pkg

// [bst_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module bst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // Storage array
  logic [AW-1:0] wr_ptr;          // Write slot
  logic [AW-1:0] rd_ptr;          // Read slot
  logic [AW:0] count;             // Words held
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;
  logic next_out_valid;           // Output valid after this edge
  logic [WIDTH-1:0] next_out_data; // Head word after this edge

  // Room flag straight from the count
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    next_out_valid = (next_count != '0);
    // A word written into the head slot bypasses the array
    next_out_data = (push && (next_rd_ptr == wr_ptr)) ? in_data : mem[next_rd_ptr];
  end

  // Register the pointers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // bst_fifo
`default_nettype wire

// [bst_tap.sv]
// Boundary scan test port: controller, scan path, crossing and output FIFO
// What this block does
// - Sample data and mode on rising test clock
// - Drive serial output on falling edges only
// - Test reset holds controller reset, scan off
// - Five mode-high edges reset the controller
// - Device software reset leaves scan untouched
// - Serial data shifts through scan path
`timescale 1ns/1ps
`default_nettype none
module bst_tap (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic test_reset_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  output logic scan_active,
  output logic word_valid,
  input wire logic word_ready,
  output bst_pkg::bst_word_s word_out
);
  import bst_pkg::*;

  bst_state_e state;               // Controller state
  bst_state_e next_state;
  logic [IR_W-1:0] ir;             // Active instruction
  logic [IR_W-1:0] next_ir;
  logic [IR_W-1:0] ir_sh;          // Instruction shift stage
  logic [IR_W-1:0] next_ir_sh;
  logic [DR_W-1:0] dr;             // Scan data shift stage
  logic [DR_W-1:0] next_dr;
  logic byp;                       // Bypass bit
  logic next_byp;
  logic next_active;
  bst_word_s upd_word;             // Word held for the system side
  bst_word_s next_upd_word;
  logic req_tog;                   // Toggles per handed word
  logic next_req_tog;
  logic ack_s1, ack_s2;            // Ack synchroniser into test clock
  logic pend;                      // Previous word not yet taken
  logic next_tdo;
  logic next_oe_n;
  logic req_s1, req_s2;            // Request synchroniser into system clock
  logic ack_tog;                   // Toggles when a word is taken
  logic next_ack_tog;
  logic [1:0] warm;                // System clock edges since reset
  logic [1:0] next_warm;
  logic sync_ready;                // Request synchroniser output trusted
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic new_word;
  logic [DR_W-1:0] fifo_out_data;

  assign pend = (req_tog != ack_s2);

  // Controller next state from mode select
  always_comb begin
    next_state = state;
    case (state)
      ST_TLR: next_state = tms ? ST_TLR : ST_RTI;
      ST_RTI: next_state = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: next_state = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: next_state = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: next_state = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: next_state = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: next_state = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_RTI;
      default: next_state = ST_TLR;
    endcase
  end

  // Scan path next values
  always_comb begin
    next_ir = ir;
    next_ir_sh = ir_sh;
    next_dr = dr;
    next_byp = byp;
    next_upd_word = upd_word;
    next_req_tog = req_tog;
    next_active = (next_state != ST_TLR);
    // Capture loads last word and a busy flag in bit 0
    if (state == ST_CAP_DR) begin
      next_dr = (ir == IR_BYPASS) ? dr : {upd_word.data[DR_W-1:1], pend};
      next_byp = 1'b0;
    end else if (state == ST_SH_DR) begin
      next_dr = (ir == IR_BYPASS) ? dr : {tdi, dr[DR_W-1:1]};
      next_byp = tdi;
    end else if (state == ST_UPD_DR && ir == IR_SCAN && !pend) begin
      next_upd_word.data = dr;
      next_req_tog = ~req_tog;
    end
    if (state == ST_CAP_IR) begin
      next_ir_sh = IR_SAMPLE;
    end else if (state == ST_SH_IR) begin
      next_ir_sh = {tdi, ir_sh[IR_W-1:1]};
    end else if (state == ST_UPD_IR) begin
      next_ir = ir_sh;
    end
    if (state == ST_TLR) begin
      next_ir = IR_RESET;
    end
  end

  // Test clock registers; only the test reset clears them
  always_ff @(posedge tck or negedge test_reset_n) begin
    if (!test_reset_n) begin
      state <= ST_TLR;
      ir <= IR_RESET;
      ir_sh <= IR_RESET;
      dr <= DR_RESET;
      byp <= 1'b0;
      scan_active <= 1'b0;
      upd_word <= '0;
      req_tog <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      state <= next_state;
      ir <= next_ir;
      ir_sh <= next_ir_sh;
      dr <= next_dr;
      byp <= next_byp;
      scan_active <= next_active;
      upd_word <= next_upd_word;
      req_tog <= next_req_tog;
      ack_s1 <= ack_tog;
      ack_s2 <= ack_s1;
    end
  end

  // Serial output select
  always_comb begin
    next_oe_n = !((state == ST_SH_DR) || (state == ST_SH_IR));
    if (state == ST_SH_IR) begin
      next_tdo = ir_sh[0];
    end else if (ir == IR_BYPASS) begin
      next_tdo = byp;
    end else begin
      next_tdo = dr[0];
    end
  end

  // Serial output changes on falling test clock
  always_ff @(negedge tck or negedge test_reset_n) begin
    if (!test_reset_n) begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else begin
      tdo <= next_tdo;
      tdo_oe_n <= next_oe_n;
    end
  end

  // System side: after reset the request level is adopted, never replayed
  assign sync_ready = (warm == SYNC_SETTLE);
  assign new_word = sync_ready && (req_s2 != ack_tog);

  // Acknowledge once the FIFO takes the word
  always_comb begin
    next_warm = sync_ready ? warm : warm + 2'h1;
    if (!sync_ready) begin
      next_ack_tog = req_s2;       // Toggle left from before reset is dropped
    end else if (new_word && fifo_in_ready) begin
      next_ack_tog = req_s2;       // Word taken by the FIFO
    end else begin
      next_ack_tog = ack_tog;      // Hold while full or idle
    end
  end

  // Register the system side crossing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      warm <= 2'h0;
      ack_tog <= 1'b0;
    end else begin
      req_s1 <= req_tog;
      req_s2 <= req_s1;
      warm <= next_warm;
      ack_tog <= next_ack_tog;
    end
  end

  // Buffer of handed words, drained by the user
  bst_fifo #(.WIDTH($bits(bst_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(new_word),
    .in_ready(fifo_in_ready),
    .in_data(upd_word.data),
    .out_valid(fifo_out_valid),
    .out_ready(word_ready),
    .out_data(fifo_out_data)
  );
  assign word_valid = fifo_out_valid;
  assign word_out.data = fifo_out_data;

  // Checks on the test clock side
  sequence s_tms_high5;
    tms [*5];
  endsequence
  sequence s_shift_scan;
    (state == ST_SH_DR) && (ir == IR_SCAN);
  endsequence

  chk_tms_five_reset: assert property (@(posedge tck) disable iff (!test_reset_n)
    s_tms_high5 |=> (state == ST_TLR)) else $error("TMS high five edges did not reset");
  chk_trst_hold: assert property (@(posedge tck)
    !test_reset_n |-> (state == ST_TLR) && !scan_active) else $error("Controller active under test reset");
  chk_tdo_falling: assert property (@(posedge tck) disable iff (!test_reset_n)
    s_shift_scan ##1 s_shift_scan |-> (tdo == dr[0]) && !tdo_oe_n) else $error("Serial output wrong");
  chk_dr_shift_in: assert property (@(posedge tck) disable iff (!test_reset_n)
    s_shift_scan |=> dr == {$past(tdi), $past(dr[DR_W-1:1])}) else $error("Scan register shift wrong");
  chk_ir_update: assert property (@(posedge tck) disable iff (!test_reset_n)
    (state == ST_UPD_IR) |=> (ir == $past(ir_sh))) else $error("Instruction not updated");
  chk_bypass_bit: assert property (@(posedge tck) disable iff (!test_reset_n)
    (state == ST_SH_DR) && (ir == IR_BYPASS) |=> byp == $past(tdi)) else $error("Bypass bit wrong");
  chk_active_flag: assert property (@(posedge tck) disable iff (!test_reset_n)
    (state == ST_TLR) && tms |=> (state == ST_TLR) && !scan_active) else $error("Scan active in reset");
  chk_word_hand: assert property (@(posedge tck) disable iff (!test_reset_n)
    (state == ST_UPD_DR) && (ir == IR_SCAN) && !pend |=> pend && (upd_word.data == $past(dr)))
    else $error("Word not handed over");
endmodule // bst_tap
`default_nettype wire

// [bst_tester.sv]
// Board tester model that drives the test port
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic test_reset_n,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  logic oe_last; // Enable seen at last rise
  logic oe_bad = 1'b0; // Enable missed in shift
  // Test clock still, test reset low from power-up
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    #1 test_reset_n = 1'b0;
  end
  // Release test reset
  task automatic go();
    #40 test_reset_n = 1'b1;
  endtask
  // One clock pulse, output taken before the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #7.5 o = tdo;
    oe_last = tdo_oe_n;
    tck = 1'b1;
    #7.5 tck = 1'b0;
  endtask
  // Walk n edges, mode bits LSB first
  task automatic seq(input logic [7:0] m, input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      step(m[i], 1'($urandom), o);
    end
  endtask
  // Shift n bits LSB first, then update and idle
  task automatic shift(input logic [7:0] din, input int n, output logic [7:0] dout);
    logic o;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
      if (oe_last !== 1'b0) oe_bad = 1'b1;
    end
    seq(8'h01, 2);
  endtask
endmodule // bst_tester
`default_nettype wire

// [bst_tap_bench.sv]
// Self-checking bench for the boundary scan test port
`timescale 1ns/1ps
`default_nettype none
module bst_tap_bench;
  import bst_pkg::*;
  logic clk = 1'b0; // System clock
  logic reset_n = 1'b0; // System reset
  logic word_ready = 1'b0; // User take
  wire logic tck, tms, tdi, test_reset_n, tdo, tdo_oe_n, scan_active, word_valid;
  bst_word_s word_out; // Head word
  int mismatches = 0;
  int n_compared = 0;
  logic [7:0] exp_q[$]; // Words due at the user side
  logic [7:0] w;
  logic [7:0] last = 8'h00; // Word last handed to the system side
  logic [7:0] got;
  // Clock
  always #50 clk = ~clk;
  bst_tap dut (.clk(clk), .reset_n(reset_n), .tck(tck), .test_reset_n(test_reset_n),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .scan_active(scan_active),
    .word_valid(word_valid), .word_ready(word_ready), .word_out(word_out));
  bst_tester far (.tck(tck), .tms(tms), .tdi(tdi), .test_reset_n(test_reset_n),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n));
  // Busy flag expected at capture of scan k
  function automatic logic exp_busy(int k);
    return k > FIFO_DEPTH;
  endfunction
  // Compare and count
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Serial output moves only while the clock is low
  always @(tdo) begin
    if (test_reset_n === 1'b1) check("tdo edge", 8'h00, {7'h0, tck});
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
  // Main sequence
  initial begin
    void'($urandom(79970));
    // Test clock runs while test reset is held low
    far.seq(8'hFF, 2);
    far.seq(8'h00, 2);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    check("oe in reset", 8'h01, {7'h0, tdo_oe_n});
    check("active in reset", 8'h00, {7'h0, scan_active});
    far.go();
    far.seq(8'h00, 1);
    check("active idle", 8'h01, {7'h0, scan_active});
    far.seq(8'h03, 4);
    far.shift({6'h0, IR_SCAN}, 2, got);
    check("ir capture", 8'h01, got);
    $display("test reset and instruction done");
    // Ten scans: eight fill, one waits, one refused
    for (int k = 0; k <= FIFO_DEPTH + 1; k++) begin
      w = 8'($urandom);
      if (k == 1) w = 8'hFF;
      if (k == 2) w = 8'h00;
      far.seq(8'h01, 3);
      far.shift(w, 8, got);
      check("busy bit", {7'h0, exp_busy(k)}, {7'h0, got[0]});
      check("capture word", {last[7:1], 1'b0}, {got[7:1], 1'b0});
      if (k <= FIFO_DEPTH) begin
        exp_q.push_back(w);
        last = w;
      end
      far.seq(8'h00, 40);
    end
    @(negedge clk);
    check("full valid", 8'h01, {7'h0, word_valid});
    foreach (exp_q[i]) begin
      @(negedge clk);
      for (int t = 0; t < 20 && word_valid !== 1'b1; t++) @(negedge clk);
      check("word", exp_q[i], word_out.data);
      @(posedge clk) word_ready <= 1'b1;
      @(posedge clk) word_ready <= 1'b0;
    end
    @(negedge clk);
    check("empty", 8'h00, {7'h0, word_valid});
    $display("test scan words done");
    // Sample instruction captures but hands nothing over
    far.seq(8'h03, 4);
    far.shift({6'h0, IR_SAMPLE}, 2, got);
    check("ir capture", 8'h01, got);
    far.seq(8'h01, 3);
    w = 8'($urandom);
    far.shift(w, 8, got);
    check("sample word", {last[7:1], 1'b0}, got);
    far.seq(8'h00, 40);
    repeat (4) @(negedge clk);
    check("sample no word", 8'h00, {7'h0, word_valid});
    // Bypass instruction: one-bit path delays data by one edge
    far.seq(8'h03, 4);
    far.shift({6'h0, IR_BYPASS}, 2, got);
    check("ir capture", 8'h01, got);
    far.seq(8'h01, 3);
    w = 8'($urandom);
    far.shift(w, 8, got);
    check("bypass path", {w[6:0], 1'b0}, got);
    $display("test sample and bypass done");
    @(posedge clk) reset_n <= 1'b0;
    @(posedge clk) reset_n <= 1'b1;
    check("active kept", 8'h01, {7'h0, scan_active});
    $display("test system reset done");
    far.seq(8'h01, 3);
    far.seq(8'h0F, 4);
    check("active four", 8'h01, {7'h0, scan_active});
    far.seq(8'h01, 1);
    check("active five", 8'h00, {7'h0, scan_active});
    check("oe in shift", 8'h00, {7'h0, far.oe_bad});
    // A word handed before the system reset must not come back
    repeat (8) @(negedge clk);
    check("no replay", 8'h00, {7'h0, word_valid});
    $display("test mode reset done");
    conclude();
  end
endmodule // bst_tap_bench
`default_nettype wire
